//--- rtl/dcfr_readout.sv
// Dither current feedback readout with its serial frame slave.
//
// Behaviour
// R1: Host requests peak/trough with read identifier 0101.
// R2: Host requests summed current with identifier 0110.
// R3: One selected channel serves both reads.
// R4: Peak/trough response layout: echo, valid, peak, trough.
// R5: Peak/trough valid clears on read, channel change.
// R6: Peak is top 11 bits of largest sum.
// R7: Trough is top 11 bits of smallest sum.
// R8: Peak reads zero until first capture.
// R9: Trough reads 2047 until first capture.
// R10: Peak/trough ready within two or one cycles.
// R11: Host checks overflow when M is 512.
// R12: Summed response layout: echo, valid, 20-bit sum.
// R13: Summed valid clears on read, channel change.
// R14: Twenty-bit current sum over one dither period.
// R15: Summed result ready within two or one cycles.
// R16: Sum scales by 2^15 times steps, else 2^13.
// R17: Host scales M=512 sums, checks overflow.
// R18: Dither cycle is four quarters of steps.
// R19: Top bit and unused bits drive zero.
`timescale 1ns/1ps
module dcfr_readout (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic adc_valid,
  input wire logic [dcfr_pkg::CH_W-1:0] adc_channel,
  input wire logic [dcfr_pkg::ADC_W-1:0] adc_data,
  input wire logic [dcfr_pkg::NCH-1:0] pwm_period_end,
  input wire logic [dcfr_pkg::STEP_W-1:0] dither_steps,
  output logic [dcfr_pkg::CH_W-1:0] channel_select
);

  // Raw pins and their two-stage synchronisers: select, clock, data.
  logic [2:0] pin_raw;
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  assign pin_raw = {spi_cs_n, spi_sclk, spi_mosi};

  // Each pin passes two flip-flops before any logic looks at it.
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        sync1_r[i] <= dcfr_pkg::SYNC_RST[i];
        sync2_r[i] <= dcfr_pkg::SYNC_RST[i];
      end else if (ce) begin
        sync1_r[i] <= pin_raw[i];
        sync2_r[i] <= sync1_r[i];
      end
    end
  end

  // Synchronised pin levels and their edges.
  wire cs_n_s = sync2_r[2];
  wire sclk_s = sync2_r[1];
  wire mosi_s = sync2_r[0];
  logic sclk_d_r; // Clock level one cycle earlier.
  logic cs_d_r; // Select level one cycle earlier.
  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire sclk_fall = ~sclk_s & sclk_d_r;
  wire cs_fall = ~cs_n_s & cs_d_r;
  wire cs_rise = cs_n_s & ~cs_d_r;

  // Edge detector history, read only after the second stage.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else if (ce) begin
      sclk_d_r <= sclk_s;
      cs_d_r <= cs_n_s;
    end
  end

  // Link state, shift registers and response holding register.
  dcfr_pkg::dcfr_link_t state_r;
  logic [dcfr_pkg::FRAME_W-1:0] rx_r; // Bits received in this frame.
  logic [dcfr_pkg::FRAME_W-1:0] tx_r; // Bits still to send in this frame.
  logic [dcfr_pkg::FRAME_W-1:0] resp_r; // Answer sent in the next frame.
  logic [dcfr_pkg::BITCNT_W-1:0] bitcnt_r; // Clock rises seen in this frame.
  logic miso_r;
  logic miso_oe_r;
  assign spi_miso = miso_r;
  assign spi_miso_oe = miso_oe_r;

  // A frame counts only if exactly 32 bits arrived before select rose.
  wire in_frame = (state_r == dcfr_pkg::DCFR_FRAME);
  wire frame_end = in_frame & cs_rise & (bitcnt_r == dcfr_pkg::BITCNT_FULL);

  // Decode of the finished frame.
  wire is_read = ~rx_r[dcfr_pkg::RW_BIT];
  wire [3:0] rx_id = rx_r[dcfr_pkg::ID_HI:dcfr_pkg::ID_LO];
  wire [dcfr_pkg::CH_W-1:0] rx_ch = rx_r[dcfr_pkg::CH_HI:dcfr_pkg::CH_LO];
  wire hit_pt = frame_end & is_read & (rx_id == dcfr_pkg::ID_PEAK_TROUGH); // R1
  wire hit_ds = frame_end & is_read & (rx_id == dcfr_pkg::ID_DITHER_SUM); // R2
  logic [dcfr_pkg::CH_W-1:0] sel_r; // Selected channel for both reads.
  wire hit_any = hit_pt | hit_ds; // R3
  wire channel_select_change = hit_any & (rx_ch != sel_r); // R3
  assign channel_select = sel_r;

  // Serial shifting: capture data on rising clock, launch on falling clock.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= dcfr_pkg::DCFR_IDLE;
      rx_r <= '0;
      tx_r <= '0;
      bitcnt_r <= '0;
      miso_r <= 1'b0;
      miso_oe_r <= 1'b0;
    end else if (ce) begin
      case (state_r)
        dcfr_pkg::DCFR_IDLE: begin
          // Select falls: load the prepared answer and drive its top bit.
          if (cs_fall) begin
            state_r <= dcfr_pkg::DCFR_FRAME;
            tx_r <= resp_r;
            bitcnt_r <= '0;
            miso_r <= resp_r[dcfr_pkg::FRAME_W-1];
            miso_oe_r <= 1'b1;
          end
        end
        dcfr_pkg::DCFR_FRAME: begin
          if (cs_rise) begin
            // Frame over: release the data line.
            state_r <= dcfr_pkg::DCFR_IDLE;
            miso_r <= 1'b0;
            miso_oe_r <= 1'b0;
          end else if (sclk_rise) begin
            // Take one bit, most significant first.
            rx_r <= {rx_r[dcfr_pkg::FRAME_W-2:0], mosi_s};
            if (bitcnt_r != '1) begin
              bitcnt_r <= bitcnt_r + 1'b1;
            end
          end else if (sclk_fall) begin
            // Launch the next answer bit.
            tx_r <= {tx_r[dcfr_pkg::FRAME_W-2:0], 1'b0};
            miso_r <= tx_r[dcfr_pkg::FRAME_W-2];
          end
        end
        default: begin
          state_r <= dcfr_pkg::DCFR_IDLE;
          miso_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // Results and their valid flags.
  logic [dcfr_pkg::FLD_W-1:0] peak_r;
  logic [dcfr_pkg::FLD_W-1:0] trough_r;
  logic [dcfr_pkg::SUM_W-1:0] dsum_r;
  logic pt_valid_r;
  logic ds_valid_r;

  // Answer words; a changed channel reports its flag as clear.
  logic [dcfr_pkg::FRAME_W-1:0] pt_word;
  logic [dcfr_pkg::FRAME_W-1:0] ds_word;
  always_comb begin
    pt_word = '0; // R19
    pt_word[dcfr_pkg::ID_HI:dcfr_pkg::ID_LO] = dcfr_pkg::ID_PEAK_TROUGH; // R4
    pt_word[dcfr_pkg::CH_HI:dcfr_pkg::CH_LO] = rx_ch; // R4
    pt_word[dcfr_pkg::PT_VALID_BIT] = pt_valid_r & ~channel_select_change; // R4
    pt_word[dcfr_pkg::PK_HI:dcfr_pkg::PK_LO] = peak_r; // R4
    pt_word[dcfr_pkg::TR_HI:dcfr_pkg::TR_LO] = trough_r; // R4
    ds_word = '0; // R19
    ds_word[dcfr_pkg::ID_HI:dcfr_pkg::ID_LO] = dcfr_pkg::ID_DITHER_SUM; // R12
    ds_word[dcfr_pkg::CH_HI:dcfr_pkg::CH_LO] = rx_ch; // R12
    ds_word[dcfr_pkg::DS_VALID_BIT] = ds_valid_r & ~channel_select_change; // R12
    ds_word[dcfr_pkg::DS_HI:dcfr_pkg::DS_LO] = dsum_r; // R12
  end

  // Prepare the answer and update the selection when a frame ends.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      resp_r <= '0;
      sel_r <= dcfr_pkg::SEL_RST;
    end else if (ce && frame_end) begin
      // Other messages belong elsewhere; this block answers them with zero.
      resp_r <= hit_pt ? pt_word : (hit_ds ? ds_word : '0);
      if (hit_any) begin
        sel_r <= rx_ch; // R3
      end
    end
  end

  // Per PWM period accumulation for the selected channel.
  wire smp_hit = adc_valid & (adc_channel == sel_r);
  wire [dcfr_pkg::ACC_W-1:0] smp_ext = {{(dcfr_pkg::ACC_W - dcfr_pkg::ADC_W){1'b0}}, adc_data};
  wire [dcfr_pkg::ACC_W-1:0] smp_add = smp_hit ? smp_ext : '0;
  wire period_end = pwm_period_end[sel_r];
  logic [dcfr_pkg::ACC_W-1:0] acc_r; // Running sum of this PWM period.
  wire [dcfr_pkg::ACC_W-1:0] psum = acc_r + smp_add; // R6

  // Dither cycle length: four quarters of the programmed steps, else one period.
  logic [dcfr_pkg::PER_W-1:0] per_cnt_r; // Periods already folded this cycle.
  logic armed_r; // A whole period boundary has been seen since restart.
  logic first_r; // Next folded period opens a dither cycle.
  wire [dcfr_pkg::PER_W-1:0] cyc_len = {dither_steps, 2'b00}; // R18
  wire cyc_last = (cyc_len == '0) | (per_cnt_r >= (cyc_len - dcfr_pkg::PER_ONE)); // R18

  // Running extremes and total of the open dither cycle.
  logic [dcfr_pkg::ACC_W-1:0] run_max_r;
  logic [dcfr_pkg::ACC_W-1:0] run_min_r;
  logic [dcfr_pkg::SUM_W-1:0] run_sum_r;
  wire [dcfr_pkg::ACC_W-1:0] new_max = (first_r || psum > run_max_r) ? psum : run_max_r; // R6
  wire [dcfr_pkg::ACC_W-1:0] new_min = (first_r || psum < run_min_r) ? psum : run_min_r; // R7
  wire [dcfr_pkg::SUM_W-1:0] part_ext = {{(dcfr_pkg::SUM_W - dcfr_pkg::PART_W){1'b0}},
                                         psum[dcfr_pkg::ACC_W-1:dcfr_pkg::PART_LSB]};
  wire [dcfr_pkg::SUM_W-1:0] new_sum = (first_r ? '0 : run_sum_r) + part_ext; // R16
  wire fold = period_end & armed_r & ~channel_select_change;
  wire capture = fold & cyc_last; // R10

  // Sample accumulation and cycle bookkeeping; a channel change restarts all.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      acc_r <= '0;
      per_cnt_r <= '0;
      armed_r <= 1'b0;
      first_r <= 1'b1;
      run_max_r <= '0;
      run_min_r <= '0;
      run_sum_r <= '0;
    end else if (ce) begin
      if (channel_select_change) begin
        // Partial data of the old channel is dropped.
        acc_r <= '0; // R10
        per_cnt_r <= '0; // R15
        armed_r <= 1'b0;
        first_r <= 1'b1;
      end else if (period_end) begin
        acc_r <= '0;
        armed_r <= 1'b1;
        if (armed_r) begin
          run_max_r <= new_max;
          run_min_r <= new_min;
          run_sum_r <= new_sum; // R14
          first_r <= cyc_last;
          per_cnt_r <= cyc_last ? '0 : per_cnt_r + dcfr_pkg::PER_ONE;
        end
      end else begin
        acc_r <= psum; // R6
      end
    end
  end

  // Captured results hold from one completed dither cycle to the next.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      peak_r <= dcfr_pkg::PEAK_RST; // R8
      trough_r <= dcfr_pkg::TROUGH_RST; // R9
      dsum_r <= '0; // R14
    end else if (ce && capture) begin
      peak_r <= new_max[dcfr_pkg::ACC_W-1:dcfr_pkg::FLD_LSB]; // R6
      trough_r <= new_min[dcfr_pkg::ACC_W-1:dcfr_pkg::FLD_LSB]; // R7
      dsum_r <= new_sum; // R14
    end
  end

  // Valid flags: a capture wins over a read clear in the same cycle.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pt_valid_r <= 1'b0; // R5
      ds_valid_r <= 1'b0; // R13
    end else if (ce) begin
      if (capture) begin
        pt_valid_r <= 1'b1; // R5
      end else if (hit_pt || channel_select_change) begin
        pt_valid_r <= 1'b0; // R5
      end
      if (capture) begin
        ds_valid_r <= 1'b1; // R13
      end else if (hit_ds || channel_select_change) begin
        ds_valid_r <= 1'b0; // R13
      end
    end
  end

endmodule

//--- rtl/dcfr_pkg.sv
// Constants and types shared by the dither current feedback readout.
package dcfr_pkg;
  // Serial frame layout.
  localparam int unsigned FRAME_W = 32; // Bits in one serial frame.
  localparam int unsigned RW_BIT = 31; // Read/write bit, low for a read.
  localparam int unsigned ID_HI = 30; // Message identifier, top bit.
  localparam int unsigned ID_LO = 27; // Message identifier, bottom bit.
  localparam int unsigned CH_HI = 26; // Channel field, top bit.
  localparam int unsigned CH_LO = 24; // Channel field, bottom bit.
  localparam int unsigned PT_VALID_BIT = 22; // Peak and trough valid flag.
  localparam int unsigned PK_HI = 21; // Peak field, top bit.
  localparam int unsigned PK_LO = 11; // Peak field, bottom bit.
  localparam int unsigned TR_HI = 10; // Trough field, top bit.
  localparam int unsigned TR_LO = 0; // Trough field, bottom bit.
  localparam int unsigned DS_VALID_BIT = 20; // Summed current valid flag.
  localparam int unsigned DS_HI = 19; // Summed current field, top bit.
  localparam int unsigned DS_LO = 0; // Summed current field, bottom bit.
  // Message identifiers served here.
  localparam logic [3:0] ID_PEAK_TROUGH = 4'h5; // Peak and trough read.
  localparam logic [3:0] ID_DITHER_SUM = 4'h6; // Summed current read.
  // Widths of the measurement path.
  localparam int unsigned CH_W = 3; // Channel number width.
  localparam int unsigned NCH = 8; // Number of channels.
  localparam int unsigned ADC_W = 10; // Converter sample width.
  localparam int unsigned ACC_W = 16; // Per PWM period sum width.
  localparam int unsigned FLD_W = 11; // Reported peak and trough width.
  localparam int unsigned FLD_LSB = ACC_W - FLD_W; // Lowest reported sum bit.
  localparam int unsigned SUM_W = 20; // Summed current width.
  localparam int unsigned PART_W = 13; // Period sum bits added to the total.
  localparam int unsigned PART_LSB = ACC_W - PART_W; // Lowest added sum bit.
  localparam int unsigned STEP_W = 5; // Dither steps per quarter width.
  localparam int unsigned PER_W = 7; // PWM period counter width.
  localparam int unsigned BITCNT_W = 6; // Frame bit counter width.
  // Reset values.
  localparam logic [FLD_W-1:0] PEAK_RST = 11'h000; // Peak before a capture.
  localparam logic [FLD_W-1:0] TROUGH_RST = 11'h7FF; // Trough before a capture.
  localparam logic [CH_W-1:0] SEL_RST = 3'h0; // Selected channel at reset.
  localparam logic [2:0] SYNC_RST = 3'h4; // Pin synchroniser reset, select idle high.
  localparam logic [BITCNT_W-1:0] BITCNT_FULL = 6'h20; // Count of a whole frame.
  localparam logic [PER_W-1:0] PER_ONE = 7'h01; // One PWM period.
  // Serial link states.
  typedef enum logic [1:0] {
    DCFR_IDLE = 2'b01,
    DCFR_FRAME = 2'b10
  } dcfr_link_t;
endpackage

//--- test/dcfr_readout_chk.sv
// Concurrent checks on the readout's serial pins and channel selection.
`timescale 1ns/1ps
module dcfr_readout_chk (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire logic [dcfr_pkg::CH_W-1:0] channel_select
);
  // All checks share the core clock and its reset; a low clock enable freezes the link, so checks rest then.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n || !ce);
  AST_MISO_IDLE: assert property (!spi_miso_oe |-> !spi_miso)
    else $error("miso high outside a frame.");
  AST_OE_IDLE: assert property (spi_cs_n [*4] |=> !spi_miso_oe)
    else $error("miso enable left on after select rose.");
  AST_OE_FRAME: assert property (!spi_cs_n [*5] |-> spi_miso_oe)
    else $error("miso enable missing in a frame.");
  AST_BIT31: assert property ($rose(spi_miso_oe) |-> !spi_miso)
    else $error("answer top bit not zero.");
  AST_SEL_HOLD: assert property (!$stable(channel_select) |-> spi_cs_n && !spi_miso_oe)
    else $error("channel changed during a frame.");
  AST_SEL_IDLE: assert property (spi_cs_n [*8] |-> $stable(channel_select))
    else $error("channel changed without a frame.");
  AST_MISO_STABLE: assert property (spi_sclk [*3] |-> $stable(spi_miso))
    else $error("miso moved while serial clock high.");
  AST_RST: assert property ($rose(reset_n) |-> channel_select == 3'h0 && !spi_miso_oe)
    else $error("wrong state after reset.");
  // Main scenarios: frames, channel changes, answers shifted out.
  cover property ($fell(spi_cs_n));
  cover property (!$stable(channel_select));
  cover property ($rose(spi_miso_oe) ##1 !spi_miso);
endmodule
bind dcfr_readout dcfr_readout_chk u_chk (
  .mclk(mclk), .reset_n(reset_n), .ce(ce), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
  .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .channel_select(channel_select)
);

//--- test/dcfr_host_model.sv
// Host side serial master model that runs full duplex frames.
`timescale 1ns/1ps
module dcfr_host_model (
  input wire logic mclk,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  // Idle: select high, serial clock parked low.
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // Sends tx MSB first and gathers the answer; each clock half lasts 4 mclk.
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    @(negedge mclk);
    spi_cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      spi_mosi = tx[i];
      repeat (4) @(negedge mclk);
      rx[i] = spi_miso;
      spi_sclk = 1'b1;
      repeat (4) @(negedge mclk);
      spi_sclk = 1'b0;
    end
    repeat (4) @(negedge mclk);
    spi_cs_n = 1'b1;
    // A released data line must not keep showing the last bit.
    spi_mosi = ~spi_mosi;
    repeat (8) @(negedge mclk);
  endtask
endmodule

//--- test/dcfr_readout_tb.sv
// Self-checking bench for the dither current feedback readout.
`timescale 1ns/1ps
module dcfr_readout_tb;
  logic mclk, reset_n, ce, adc_valid, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic [2:0] adc_channel, channel_select;
  logic [9:0] adc_data;
  logic [7:0] pwm_period_end;
  logic [4:0] dither_steps;
  logic [31:0] seed = 32'h0000002F;
  logic [31:0] rx;
  logic [15:0] psum, mx, mn;
  logic [19:0] tot = 20'h00000;
  logic [10:0] pk = 11'h000;
  logic [10:0] tr = 11'h7FF;
  int num_errors = 0;
  int n_checks = 0;
  int steps_tab [5] = '{0, 1, 3, 31, 2};
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  dcfr_readout u_dut (.mclk(mclk), .reset_n(reset_n), .ce(ce), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .adc_valid(adc_valid),
    .adc_channel(adc_channel), .adc_data(adc_data), .pwm_period_end(pwm_period_end),
    .dither_steps(dither_steps), .channel_select(channel_select));
  dcfr_host_model host (.mclk(mclk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso));
  // Xorshift source of the random stimulus.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected answers, built from the results the bench has worked out.
  function automatic logic [31:0] exp_pt(input logic [2:0] ch, input logic v);
    return {1'b0, dcfr_pkg::ID_PEAK_TROUGH, ch, 1'b0, v, pk, tr};
  endfunction
  function automatic logic [31:0] exp_ds(input logic [2:0] ch, input logic v);
    return {1'b0, dcfr_pkg::ID_DITHER_SUM, ch, 3'h0, v, tot};
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, want, seen);
    end
  endtask
  // Read request, then an unserved write frame to fetch the answer.
  task automatic chkrd(input logic [3:0] id, input logic [2:0] ch, input logic v);
    host.xfer({1'b0, id, ch, 24'h000000}, rx);
    check("null", rx, 32'h00000000);
    host.xfer(32'h80000000, rx);
    check("resp", rx, (id == dcfr_pkg::ID_PEAK_TROUGH) ? exp_pt(ch, v) : exp_ds(ch, v));
  endtask
  // One arming period, then a whole dither cycle; other channels add noise.
  task automatic run_cycle(input logic [2:0] ch, input int n);
    mx = 16'h0000;
    mn = 16'hFFFF;
    tot = 20'h00000;
    dither_steps = n[4:0];
    for (int p = 0; p <= ((n == 0) ? 1 : 4 * n); p++) begin
      psum = 16'h0000;
      // Four selected samples per period keep every field clear of overflow.
      for (int s = 0; s < 8; s++) begin
        @(negedge mclk);
        adc_valid = 1'b1;
        adc_channel = s[0] ? ch + 3'h1 : ch;
        adc_data = (p == 1) ? 10'h3FF : 10'(rnd());
        pwm_period_end = (s == 7) ? 8'h01 << ch : 8'(rnd()) & ~(8'h01 << ch);
        if (!s[0]) psum += 16'(adc_data);
      end
      if (p > 0 && psum > mx) mx = psum;
      if (p > 0 && psum < mn) mn = psum;
      if (p > 0) tot += 20'(psum[15:3]);
    end
    @(negedge mclk);
    adc_valid = 1'b0;
    pwm_period_end = 8'h00;
    repeat (4) @(negedge mclk);
    pk = mx[15:5];
    tr = mn[15:5];
  endtask
  task automatic test_done();
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Watchdog against a hung run.
  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    test_done();
  end
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    adc_valid = 1'b0;
    adc_channel = 3'h0;
    adc_data = 10'h000;
    pwm_period_end = 8'h00;
    dither_steps = 5'h00;
    repeat (16) @(negedge mclk);
    reset_n = 1'b1;
    repeat (4) @(negedge mclk);
    // Pass k selects channel k and leaves one flag unread for the next.
    for (int k = 0; k < 5; k++) begin
      chkrd(k[0] ? dcfr_pkg::ID_PEAK_TROUGH : dcfr_pkg::ID_DITHER_SUM, 3'(k), 1'b0);
      chkrd(k[0] ? dcfr_pkg::ID_DITHER_SUM : dcfr_pkg::ID_PEAK_TROUGH, 3'(k), 1'b0);
      run_cycle(3'(k), steps_tab[k]);
      chkrd(k[0] ? dcfr_pkg::ID_DITHER_SUM : dcfr_pkg::ID_PEAK_TROUGH, 3'(k), 1'b1);
      chkrd(k[0] ? dcfr_pkg::ID_DITHER_SUM : dcfr_pkg::ID_PEAK_TROUGH, 3'(k), 1'b0);
    end
    // A frame sent while the clock enable is low is lost and leaves the selection alone.
    ce = 1'b0;
    host.xfer({1'b0, dcfr_pkg::ID_DITHER_SUM, 3'h6, 24'h000000}, rx);
    ce = 1'b1;
    check("frozen_sel", {29'h0, channel_select}, 32'h00000004);
    // A write to a served identifier changes nothing and is answered with zero.
    host.xfer({1'b1, dcfr_pkg::ID_PEAK_TROUGH, 3'h7, 24'h000000}, rx);
    check("null", rx, 32'h00000000);
    host.xfer(32'h80000000, rx);
    check("write_resp", rx, 32'h00000000);
    check("write_sel", {29'h0, channel_select}, 32'h00000004);
    // A second reset in mid-run brings back the reset results and selection.
    @(negedge mclk);
    reset_n = 1'b0;
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    repeat (4) @(negedge mclk);
    pk = 11'h000;
    tr = 11'h7FF;
    tot = 20'h00000;
    check("reset_sel", {29'h0, channel_select}, 32'h00000000);
    chkrd(dcfr_pkg::ID_PEAK_TROUGH, 3'h0, 1'b0);
    chkrd(dcfr_pkg::ID_DITHER_SUM, 3'h0, 1'b0);
    test_done();
  end
endmodule
